// >>> design/btc_device.sv
// Functional notes
// - Blocked PCI accesses are answered with retry
// - Block bit loads strap during reset
// - Local processor clears block, PCI then served
// - Serial ROM may load block; writes still allowed
// - Per-image select picks common or image counts
// - Hold bit keeps local bus busy between cycles
// - Keep hold bit clear with DMA memory controller
// - Retry limit codes: unlimited, 128, 256, 384
// - Stall disconnect after eight wait clocks
// - Target abort mapping gives local bus error
// - Master abort disable decides abort mapping
// - Full-burst bit forces four phase bursts
// - Single-beat bit selects single prefetch cycles
// - Image1 count resets 000001, bytes four times
// - Posted write boost selects improved dequeuing
// - Parity sense: zero even, one odd
// - ROM access enable when no ROM fitted
// - Ordering disable drops channel ordering
// - Wake from D3hot resets when enabled
// - Interrupt in D3hot may drive wake event
// - Set speed bits when ordering not needed
`timescale 1ns/10ps
`default_nettype none
module btc_device #(
    parameter int LRST_LEN  = btc_pkg::LRST_CYCLES,
    parameter int STALL_MAX = btc_pkg::STALL_CLOCKS
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Link to host and local processor
    btc_link_if.dev         link,
    // Power-up straps
    input  wire logic       strap_access_block,
    input  wire logic       strap_rom_data,
    input  wire logic       strap_rom_present,
    // Serial ROM load
    input  wire logic       rom_load_valid,
    input  wire logic       rom_load_block,
    // Prefetch and target channel
    input  wire logic [5:0] prefetch_count_image0,
    input  wire logic       tgt_image,
    input  wire logic       tgt_cycle_active,
    input  wire logic       tgt_next_pending,
    input  wire logic       tgt_data_wait,
    output logic [7:0]      prefetch_bytes,
    output logic            local_bus_busy,
    output logic            prefetch_disconnect,
    // Master channel
    output logic [8:0]      retry_max,
    input  wire logic       pci_target_abort,
    input  wire logic       pci_master_abort,
    input  wire logic       delayed_cycle,
    input  wire logic       master_abort_map_disable,
    output logic            local_bus_error,
    output logic            local_normal_done,
    // Local burst shape
    input  wire logic [2:0] wr_phases_req,
    output logic [2:0]      burst_phases,
    output logic            prefetch_use_burst,
    output logic            slave_posted_write_boost,
    output logic            ordering_enforced,
    // Parity
    input  wire logic [31:0] parity_data,
    output logic            parity_bit,
    // Serial ROM
    output logic            serial_rom_enabled,
    // Power and reset
    input  wire logic       d3hot_wake_support,
    input  wire logic       local_interrupt_in,
    output logic            local_reset_out,
    output logic            internal_reset
);
    import btc_pkg::*;

    // ****************************************************
    // Decoding helpers
    // ****************************************************
    function automatic logic [8:0] retry_cap(input logic [1:0] code);
        logic [8:0] cap;
        cap = 9'h000;
        unique case (code)
            2'h1: cap = RETRY_CAP_1;
            2'h2: cap = RETRY_CAP_2;
            2'h3: cap = RETRY_CAP_3;
            2'h0: cap = 9'h000;
        endcase
        return cap;
    endfunction

    function automatic logic hits(input logic [ADDR_W-1:0] a);
        return a == OFS_TUNING_CTL;
    endfunction

    // ****************************************************
    // Control register and field views
    // ****************************************************
    logic [31:0] ctl;
    logic        rom_fitted;
    logic [31:0] next_ctl;

    wire access_block   = ctl[BIT_ACCESS_BLOCK];
    wire per_image      = ctl[BIT_PER_IMAGE];
    wire hold_bus_busy  = ctl[BIT_HOLD_BUSY];
    wire [1:0] retry_limit = ctl[BIT_RETRY_HI:BIT_RETRY_LO];
    wire stall_disc     = ctl[BIT_STALL_DISC];
    wire tabort_map     = ctl[BIT_TABORT_MAP];
    wire full_burst     = ctl[BIT_FULL_BURST];
    wire single_beat    = ctl[BIT_SINGLE_BEAT];
    wire [5:0] count1   = ctl[BIT_COUNT1_HI:BIT_COUNT1_LO];
    wire posted_boost   = ctl[BIT_POSTED_BOOST];
    wire port_parking   = ctl[BIT_PORT_PARKING];
    wire parity_odd     = ctl[BIT_PARITY_SENSE];
    wire rom_access     = ctl[BIT_ROM_ACCESS];
    wire order_disable  = ctl[BIT_ORDER_DISABLE];
    wire wake_reset     = ctl[BIT_WAKE_RESET];
    wire int_wake       = ctl[BIT_INT_WAKE];

    // ****************************************************
    // Register port
    // ****************************************************
    logic pci_ack;
    logic pci_retry;
    logic loc_ack;
    logic grant_pci;
    logic grant_loc;

    // A request still high in its acknowledge cycle is the old one
    wire pci_new   = link.pci_req & ~pci_ack;
    wire loc_new   = link.loc_req & ~loc_ack;
    wire pci_bump  = pci_new & access_block;
    wire pci_want  = pci_new & ~access_block;

    btc_port_arb u_arb (
        .clk       (clk),
        .reset     (reset),
        .pci_want  (pci_want),
        .loc_want  (loc_new),
        .parking   (port_parking),
        .grant_pci (grant_pci),
        .grant_loc (grant_loc)
    );

    wire pci_wr = grant_pci & link.pci_we & hits(link.pci_addr);
    wire loc_wr = grant_loc & link.loc_we & hits(link.loc_addr);
    wire [31:0] wr_data = grant_loc ? link.loc_wdata : link.pci_wdata;
    wire [31:0] rd_view = ctl & TUNING_WMASK;

    always_comb begin
        next_ctl = ctl;
        if (rom_load_valid) begin
            next_ctl[BIT_ACCESS_BLOCK] = rom_load_block;
        end
        if (pci_wr | loc_wr) begin
            next_ctl = wr_data & TUNING_WMASK;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ctl                   <= TUNING_RESET;
            ctl[BIT_ACCESS_BLOCK] <= strap_access_block;
            rom_fitted            <= strap_rom_data | strap_rom_present;
        end else begin
            ctl <= next_ctl;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pci_ack       <= 1'b0;
            pci_retry     <= 1'b0;
            loc_ack       <= 1'b0;
            link.pci_rdata <= 32'h0000_0000;
            link.loc_rdata <= 32'h0000_0000;
        end else begin
            pci_ack   <= grant_pci | pci_bump;
            pci_retry <= pci_bump;
            loc_ack   <= grant_loc;
            if (grant_pci) begin
                link.pci_rdata <= hits(link.pci_addr) ? rd_view : 32'h0000_0000;
            end
            if (grant_loc) begin
                link.loc_rdata <= hits(link.loc_addr) ? rd_view : 32'h0000_0000;
            end
        end
    end

    assign link.pci_ack   = pci_ack;
    assign link.pci_retry = pci_retry;
    assign link.loc_ack   = loc_ack;

    // ****************************************************
    // Target channel stall watch
    // ****************************************************
    logic [$clog2(STALL_MAX+1)-1:0] stall_cnt;
    wire stall_full = stall_cnt == ($clog2(STALL_MAX+1))'(STALL_MAX);

    always_ff @(posedge clk) begin
        if (reset || !tgt_data_wait) begin
            stall_cnt <= '0;
        end else if (!stall_full) begin
            stall_cnt <= stall_cnt + 1'b1;
        end
    end

    // ****************************************************
    // Power state and wake
    // ****************************************************
    logic       was_d3hot;
    logic [$clog2(LRST_LEN+1)-1:0] lrst_cnt;
    // Only the host-driven D3hot to D0 step counts, never a reset
    wire wake_step = was_d3hot & ~link.power_d3hot & wake_reset;

    always_ff @(posedge clk) begin
        if (reset) begin
            was_d3hot <= 1'b0;
            lrst_cnt  <= '0;
        end else begin
            was_d3hot <= link.power_d3hot;
            if (wake_step) begin
                lrst_cnt <= ($clog2(LRST_LEN+1))'(LRST_LEN);
            end else if (lrst_cnt != '0) begin
                lrst_cnt <= lrst_cnt - 1'b1;
            end
        end
    end

    // Open-drain wake request: drive low while enabled
    assign link.pme_o  = 1'b0;
    assign link.pme_oe = int_wake & d3hot_wake_support
                         & link.power_d3hot & local_interrupt_in;

    // ****************************************************
    // Registered mode outputs
    // ****************************************************
    wire [5:0] count_sel = (per_image & tgt_image) ? count1 : prefetch_count_image0;
    wire       abort_err = tabort_map ? pci_target_abort
                         : (pci_target_abort & ~master_abort_map_disable);

    always_ff @(posedge clk) begin
        if (reset) begin
            prefetch_bytes           <= 8'h00;
            local_bus_busy           <= 1'b0;
            prefetch_disconnect      <= 1'b0;
            retry_max                <= 9'h000;
            local_bus_error          <= 1'b0;
            local_normal_done        <= 1'b0;
            burst_phases             <= 3'h0;
            prefetch_use_burst       <= 1'b0;
            slave_posted_write_boost <= 1'b0;
            ordering_enforced        <= 1'b0;
            parity_bit               <= 1'b0;
            serial_rom_enabled       <= 1'b0;
            local_reset_out          <= 1'b0;
            internal_reset           <= 1'b0;
        end else begin
            prefetch_bytes      <= {count_sel, 2'h0};
            local_bus_busy      <= tgt_cycle_active
                                   | (hold_bus_busy & tgt_next_pending);
            prefetch_disconnect <= stall_disc & tgt_data_wait & stall_full;
            retry_max           <= retry_cap(retry_limit);
            local_bus_error     <= delayed_cycle & (abort_err
                                   | (pci_master_abort & ~master_abort_map_disable));
            local_normal_done   <= delayed_cycle & pci_target_abort & ~abort_err;
            burst_phases        <= full_burst ? FULL_PHASES : wr_phases_req;
            prefetch_use_burst  <= ~single_beat;
            slave_posted_write_boost <= posted_boost;
            ordering_enforced   <= ~order_disable;
            parity_bit          <= ^parity_data ^ parity_odd;
            serial_rom_enabled  <= rom_fitted | rom_access;
            local_reset_out     <= wake_step | (lrst_cnt > 1);
            internal_reset      <= wake_step;
        end
    end
endmodule
`default_nettype wire

// >>> design/btc_pkg.sv
package btc_pkg;
    // ****************************************************
    // Register map
    // ****************************************************
    localparam int          ADDR_W         = 12;
    localparam logic [11:0] OFS_TUNING_CTL = 12'h808;
    localparam logic [31:0] TUNING_RESET   = 32'h0000_0400;
    // Reserved positions are dropped on write and read back as zero
    localparam logic [31:0] TUNING_WMASK   = 32'h80ff_ff1f;

    // ****************************************************
    // Field positions
    // ****************************************************
    localparam int BIT_ACCESS_BLOCK   = 31;
    localparam int BIT_PER_IMAGE      = 23;
    localparam int BIT_HOLD_BUSY      = 22;
    localparam int BIT_RETRY_HI       = 21;
    localparam int BIT_RETRY_LO       = 20;
    localparam int BIT_STALL_DISC     = 19;
    localparam int BIT_TABORT_MAP     = 18;
    localparam int BIT_FULL_BURST     = 17;
    localparam int BIT_SINGLE_BEAT    = 16;
    localparam int BIT_COUNT1_HI      = 15;
    localparam int BIT_COUNT1_LO      = 10;
    localparam int BIT_POSTED_BOOST   = 9;
    localparam int BIT_PORT_PARKING   = 8;
    localparam int BIT_PARITY_SENSE   = 4;
    localparam int BIT_ROM_ACCESS     = 3;
    localparam int BIT_ORDER_DISABLE  = 2;
    localparam int BIT_WAKE_RESET     = 1;
    localparam int BIT_INT_WAKE       = 0;

    // ****************************************************
    // Encodings and counts
    // ****************************************************
    localparam logic [8:0] RETRY_CAP_1   = 9'h080;
    localparam logic [8:0] RETRY_CAP_2   = 9'h100;
    localparam logic [8:0] RETRY_CAP_3   = 9'h180;
    localparam logic [2:0] FULL_PHASES   = 3'h4;
    localparam int         STALL_CLOCKS  = 8;
    localparam int         LRST_CYCLES   = 16;
endpackage

// >>> design/btc_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface btc_link_if;
    import btc_pkg::*;
    // PCI side register access
    logic              pci_req;
    logic              pci_we;
    logic [ADDR_W-1:0] pci_addr;
    logic [31:0]       pci_wdata;
    logic              pci_ack;
    logic              pci_retry;
    logic [31:0]       pci_rdata;
    // Local processor register access
    logic              loc_req;
    logic              loc_we;
    logic [ADDR_W-1:0] loc_addr;
    logic [31:0]       loc_wdata;
    logic              loc_ack;
    logic [31:0]       loc_rdata;
    // Power management
    logic              power_d3hot;
    logic              pme_o;
    logic              pme_oe;

    modport dev (
        input  pci_req, pci_we, pci_addr, pci_wdata,
        output pci_ack, pci_retry, pci_rdata,
        input  loc_req, loc_we, loc_addr, loc_wdata,
        output loc_ack, loc_rdata,
        input  power_d3hot,
        output pme_o, pme_oe
    );
    modport host (
        output pci_req, pci_we, pci_addr, pci_wdata,
        input  pci_ack, pci_retry, pci_rdata,
        output loc_req, loc_we, loc_addr, loc_wdata,
        input  loc_ack, loc_rdata,
        output power_d3hot,
        input  pme_o, pme_oe
    );
endinterface
`default_nettype wire

// >>> design/btc_port_arb.sv
`timescale 1ns/10ps
`default_nettype none
module btc_port_arb (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // Requests and mode
    input  wire logic pci_want,
    input  wire logic loc_want,
    input  wire logic parking,
    // Grants
    output logic      grant_pci,
    output logic      grant_loc
);
    import btc_pkg::*;

    logic last_loc;
    wire  both     = pci_want & loc_want;
    // Parking favours the bus that used the port last; otherwise PCI owns ties
    wire  tie_loc  = parking & last_loc;

    assign grant_pci = pci_want & ~(both & tie_loc);
    assign grant_loc = loc_want & ~grant_pci;

    always_ff @(posedge clk) begin
        if (reset) begin
            last_loc <= 1'b0;
        end else if (grant_pci | grant_loc) begin
            last_loc <= grant_loc;
        end
    end
endmodule
`default_nettype wire

// >>> design/btc_host.sv
`timescale 1ns/10ps
`default_nettype none
module btc_host (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    // Link to the device
    btc_link_if.host               link,
    // Command port
    input  wire logic              cmd_valid,
    input  wire logic              cmd_local,
    input  wire logic              cmd_we,
    input  wire logic [11:0]       cmd_addr,
    input  wire logic [31:0]       cmd_wdata,
    output logic                   cmd_ready,
    // Answer port
    output logic                   rsp_valid,
    output logic                   rsp_retry,
    output logic [31:0]            rsp_rdata,
    // Power control
    input  wire logic              go_d3hot,
    output logic                   wake_seen
);
    import btc_pkg::*;

    typedef enum logic [1:0] {
        HST_IDLE = 2'b01,
        HST_WAIT = 2'b10
    } btc_hst_e;

    btc_hst_e state;
    btc_hst_e next_state;
    logic     use_loc;
    logic     next_use_loc;

    wire take    = cmd_valid & (state == HST_IDLE);
    wire got_ack = use_loc ? link.loc_ack : link.pci_ack;

    assign cmd_ready = state == HST_IDLE;
    assign wake_seen = link.pme_oe & ~link.pme_o;

    always_comb begin
        next_state   = state;
        next_use_loc = use_loc;
        unique case (state)
            HST_IDLE: begin
                if (cmd_valid) begin
                    next_state   = HST_WAIT;
                    next_use_loc = cmd_local;
                end
            end
            HST_WAIT: begin
                if (got_ack) begin
                    next_state = HST_IDLE;
                end
            end
            default: next_state = HST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state            <= HST_IDLE;
            use_loc          <= 1'b0;
            link.pci_req     <= 1'b0;
            link.loc_req     <= 1'b0;
            link.pci_we      <= 1'b0;
            link.loc_we      <= 1'b0;
            link.pci_addr    <= '0;
            link.loc_addr    <= '0;
            link.pci_wdata   <= 32'h0000_0000;
            link.loc_wdata   <= 32'h0000_0000;
            link.power_d3hot <= 1'b0;
            rsp_valid        <= 1'b0;
            rsp_retry        <= 1'b0;
            rsp_rdata        <= 32'h0000_0000;
        end else begin
            state            <= next_state;
            use_loc          <= next_use_loc;
            link.power_d3hot <= go_d3hot;
            rsp_valid        <= (state == HST_WAIT) & got_ack;
            rsp_retry        <= (state == HST_WAIT) & got_ack & ~use_loc
                                & link.pci_retry;
            if ((state == HST_WAIT) & got_ack) begin
                rsp_rdata    <= use_loc ? link.loc_rdata : link.pci_rdata;
                link.pci_req <= 1'b0;
                link.loc_req <= 1'b0;
            end
            if (take) begin
                // Command goes out on the local port or the PCI port as cmd_local selects
                link.loc_req   <= cmd_local;
                link.pci_req   <= ~cmd_local;
                link.loc_we    <= cmd_we;
                link.pci_we    <= cmd_we;
                link.loc_addr  <= cmd_addr;
                link.pci_addr  <= cmd_addr;
                link.loc_wdata <= cmd_wdata;
                link.pci_wdata <= cmd_wdata;
            end
        end
    end
endmodule
`default_nettype wire

// >>> bench/btc_link_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module btc_link_asserts
    import btc_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        reset,
    // Register ports
    input wire logic        pci_req,
    input wire logic        pci_ack,
    input wire logic        pci_retry,
    input wire logic [31:0] pci_rdata,
    input wire logic        loc_req,
    input wire logic        loc_ack,
    input wire logic [31:0] loc_rdata,
    // Power management
    input wire logic        power_d3hot,
    input wire logic        pme_o,
    input wire logic        pme_oe
);
    // ****************************************
    // Link checks
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    property p_retry_ack;
        pci_retry |-> pci_ack;
    endproperty
    a_retry_ack: assert property (p_retry_ack) else $error("retry without ack");
    property p_pci_ans;
        $rose(pci_req) |-> ##[1:4] pci_ack;
    endproperty
    a_pci_ans: assert property (p_pci_ans) else $error("pci request unanswered");
    property p_pci_pulse;
        pci_ack |=> !pci_ack;
    endproperty
    a_pci_pulse: assert property (p_pci_pulse) else $error("pci ack too long");
    property p_loc_ans;
        $rose(loc_req) |-> ##[1:4] loc_ack;
    endproperty
    a_loc_ans: assert property (p_loc_ans) else $error("local request unanswered");
    property p_loc_pulse;
        loc_ack |=> !loc_ack;
    endproperty
    a_loc_pulse: assert property (p_loc_pulse) else $error("local ack too long");
    property p_pci_resv;
        pci_ack |-> (pci_rdata & ~TUNING_WMASK) == 32'h0;
    endproperty
    a_pci_resv: assert property (p_pci_resv) else $error("pci reserved bits set");
    property p_loc_resv;
        loc_ack |-> (loc_rdata & ~TUNING_WMASK) == 32'h0;
    endproperty
    a_loc_resv: assert property (p_loc_resv) else $error("local reserved bits set");
    property p_pme;
        pme_oe |-> power_d3hot && !pme_o;
    endproperty
    a_pme: assert property (p_pme) else $error("wake pin outside d3hot");
endmodule
`default_nettype wire

// >>> bench/bridge_misc_control_two_tb.sv
`timescale 1ns/10ps
`default_nettype none
module bridge_misc_control_two_tb;
    import btc_pkg::*;
    logic clk, reset, cmd_valid, cmd_local, cmd_we, cmd_ready, rsp_valid, rsp_retry, go_d3hot, wake_seen;
    logic [11:0] cmd_addr;
    logic [31:0] cmd_wdata, rsp_rdata, pdat, m, rd, d;
    logic s_blk, s_rd, s_rp, rl_v, rl_b, img, act, pend, dwait, ta, ma, dly, madis, pmsup, lint, rt, e;
    logic [5:0] cnt0;
    logic [2:0] wph, bph;
    logic [7:0] pbytes;
    logic [8:0] rmax;
    logic busy, disc, berr, ndone, pburst, boost, ord, par, rom_en, lrst, irst;
    int err_count, n_compared, cyc, seed, i, lc, ic;

    btc_link_if btc_link_if_i ();
    btc_device #(.LRST_LEN(4)) btc_device_i (.clk(clk), .reset(reset), .link(btc_link_if_i),
        .strap_access_block(s_blk), .strap_rom_data(s_rd), .strap_rom_present(s_rp),
        .rom_load_valid(rl_v), .rom_load_block(rl_b), .prefetch_count_image0(cnt0), .tgt_image(img),
        .tgt_cycle_active(act), .tgt_next_pending(pend), .tgt_data_wait(dwait), .prefetch_bytes(pbytes),
        .local_bus_busy(busy), .prefetch_disconnect(disc), .retry_max(rmax), .pci_target_abort(ta),
        .pci_master_abort(ma), .delayed_cycle(dly), .master_abort_map_disable(madis),
        .local_bus_error(berr), .local_normal_done(ndone), .wr_phases_req(wph), .burst_phases(bph),
        .prefetch_use_burst(pburst), .slave_posted_write_boost(boost), .ordering_enforced(ord),
        .parity_data(pdat), .parity_bit(par), .serial_rom_enabled(rom_en), .d3hot_wake_support(pmsup),
        .local_interrupt_in(lint), .local_reset_out(lrst), .internal_reset(irst));
    btc_host btc_host_i (.clk(clk), .reset(reset), .link(btc_link_if_i), .cmd_valid(cmd_valid),
        .cmd_local(cmd_local), .cmd_we(cmd_we), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_retry(rsp_retry), .rsp_rdata(rsp_rdata),
        .go_d3hot(go_d3hot), .wake_seen(wake_seen));
    btc_link_asserts btc_link_asserts_i (.clk(clk), .reset(reset), .pci_req(btc_link_if_i.pci_req),
        .pci_ack(btc_link_if_i.pci_ack), .pci_retry(btc_link_if_i.pci_retry),
        .pci_rdata(btc_link_if_i.pci_rdata), .loc_req(btc_link_if_i.loc_req),
        .loc_ack(btc_link_if_i.loc_ack), .loc_rdata(btc_link_if_i.loc_rdata),
        .power_d3hot(btc_link_if_i.power_d3hot), .pme_o(btc_link_if_i.pme_o), .pme_oe(btc_link_if_i.pme_oe));

    // ****************************************
    // Checking and closing
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Hang guard: all traffic below needs well under this many cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 8000) begin
            err_count++;
            conclude();
        end
    end

    // ****************************************
    // Register access through the host
    // ****************************************
    task automatic acc(input logic lb, input logic we, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        {cmd_local, cmd_we, cmd_addr, cmd_wdata} = {lb, we, a, wd};
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        chk(n < 20, 1);
        rd = rsp_rdata;
        rt = rsp_retry;
        @(negedge clk);
    endtask

    // Model follows writes; a blocked PCI write must leave it alone
    task automatic wr(input logic lb, input logic [31:0] wd);
        acc(lb, 1'b1, OFS_TUNING_CTL, wd);
        if (lb || !m[31])
            m = wd & TUNING_WMASK;
        repeat (2) @(negedge clk);
    endtask

    task automatic rdchk(input logic lb);
        acc(lb, 1'b0, OFS_TUNING_CTL, 32'h0);
        chk(rt, !lb && m[31]);
        if (!rt)
            chk(rd, m);
    endtask

    initial begin
        {cmd_valid, cmd_local, cmd_we, cmd_addr, cmd_wdata, go_d3hot, s_rd, s_rp, rl_v, rl_b} = '0;
        {img, act, pend, dwait, ta, ma, dly, madis, pmsup, lint, cnt0, wph, pdat} = '0;
        seed = 32'h8b51e0c1;
        s_blk = 1'b1;
        reset = 1'b1;
        repeat (10) @(negedge clk);
        reset = 1'b0;
        m = TUNING_RESET | 32'h8000_0000;
        rdchk(1);
        rdchk(0);
        wr(0, 32'h0000_0f00);
        rdchk(1);
        wr(1, 32'h0);
        rdchk(0);
        for (i = 0; i < 16; i++) begin
            wr(1'($random(seed)), $random(seed));
            rdchk(1'($random(seed)));
        end
        acc(1, 1'b0, 12'h80c, 32'h0);
        chk(rd, 32'h0);
        {rl_b, rl_v} = 2'b11;
        @(negedge clk);
        rl_v = 1'b0;
        m[31] = 1'b1;
        rdchk(0);
        wr(1, 32'h0000_0400);
        rdchk(0);
        for (i = 0; i < 8; i++) begin
            d = $random(seed);
            d[21:20] = i[1:0];
            {cnt0, img, pdat} = 39'({$random(seed), $random(seed)});
            wph = {2'b01, 1'($random(seed))};
            {act, pend} = 2'b01;
            wr(1, d);
            chk(rmax, {d[21:20], 7'h00});
            chk(pbytes, {(d[23] && img) ? d[15:10] : cnt0, 2'b00});
            chk(bph, d[17] ? FULL_PHASES : wph);
            chk(busy, d[22]);
            chk({pburst, boost, ord, rom_en}, {!d[16], d[9], !d[2], d[3]});
            chk(par, ^pdat ^ d[4]);
        end
        // Mid-run reset with the strap low: block bit and image 1 count come back
        {reset, s_blk} = 2'b10;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        m = TUNING_RESET;
        rdchk(1);
        chk(rd[15:10], 6'h01);
        for (i = 0; i < 32; i++) begin
            wr(1, {13'h0, i[4], 18'h0});
            {ta, ma, madis, dly} = i[3:0];
            repeat (2) @(negedge clk);
            e = dly & (ta & (i[4] | !madis) | ma & !madis);
            chk(berr, e);
            chk(ndone, dly & ta & !e);
        end
        wr(1, 32'h000a_0304);
        chk({bph, ord, boost}, {FULL_PHASES, 1'b0, 1'b1});
        dwait = 1'b1;
        repeat (8) @(negedge clk);
        chk(disc, 0);
        repeat (1) @(negedge clk);
        chk(disc, 1);
        dwait = 1'b0;
        for (i = 0; i < 2; i++) begin
            wr(1, {30'h0, i[0], i[0]});
            {pmsup, go_d3hot} = 2'b11;
            repeat (3) @(negedge clk);
            lint = 1'b1;
            lc = 0;
            repeat (4) @(negedge clk) lc += wake_seen;
            chk(lc > 0, i);
            {lint, go_d3hot} = 2'b00;
            {lc, ic} = '0;
            repeat (20) @(negedge clk) begin
                lc += lrst;
                ic += irst;
            end
            chk(lc, i * 4);
            chk(ic, i);
        end
        conclude();
    end
endmodule
`default_nettype wire
